// ### bench/latched_eeprom_write_gate_tb.sv
/*
  self-checking bench for the byte update controller.
  assumes the behavioural memory model on the far side of the pins.
*/
`timescale 1ns/1ps
module latched_eeprom_write_gate_tb;
  // ****************************************
  // signals and bench model
  // ****************************************
  localparam int TWP = 20;
  logic                       clk_i = 1'b0;
  logic                       rstn_i, req_i, wp, ready_o, done_o, ok_o;
  logic [10:0]                addr_i;
  logic [0:0]                 dev_i, cur_dev;
  logic [7:0]                 wdata_i, rdata_o, mem_dq;
  eeprom_gate_pkg::mem_pins_t mem_o;
  logic [7:0]                 exp_mem [0:4095];
  logic [7:0]                 lat_q[$];
  logic [10:0]                lat_a[$];
  logic                       we_prev = 1'b1;
  logic                       oe_prev = 1'b1;
  int                         low_cnt, miscompares = 0, checked = 0;
  logic [31:0]                r;

  eeprom_update_ctrl #(.TWP_CYC(TWP)) i_eeprom_update_ctrl (
    .clk_i(clk_i), .rstn_i(rstn_i), .req_i(req_i), .addr_i(addr_i), .dev_i(dev_i),
    .wdata_i(wdata_i), .ready_o(ready_o), .done_o(done_o), .ok_o(ok_o),
    .rdata_o(rdata_o), .mem_dq_i(mem_dq), .mem_o(mem_o));
  latched_mem_model #(.TWP_MIN(TWP)) i_latched_mem_model (
    .clk_i(clk_i), .wp_i(wp), .mem_i(mem_o), .dq_o(mem_dq));

  // 50 MHz clock
  initial begin
    forever #10 clk_i = ~clk_i;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // strobe watcher on settled pins
  always @(negedge clk_i) begin
    if (!rstn_i) begin
      we_prev = 1'b1;
      low_cnt = 0;
    end else begin
      if (mem_o.oe_n === 1'b0) check(mem_o.ce_n, 0);
      if (mem_o.we_n === 1'b0) begin
        if (we_prev) begin
          check(mem_o.oe_n, 1);
          check(mem_o.dout_oe, 1);
          check(mem_o.cs_n, 2'(~(2'b01 << cur_dev)));
          lat_q.push_back(mem_o.dout);
          lat_a.push_back(mem_o.addr);
        end
        check(mem_o.ce_n, 0);
        low_cnt++;
      end else if (!we_prev) begin
        check(low_cnt >= TWP, 1);
        check(oe_prev, 0);
        check(mem_o.ce_n, 0);
        low_cnt = 0;
      end
      we_prev = mem_o.we_n;
      oe_prev = mem_o.oe_n;
    end
  end

  // one byte update, optionally with a refused request while busy
  task automatic update(input logic [0:0] d, input logic [10:0] a, input logic [7:0] w,
                        input bit intr);
    int i;
    logic [7:0] old;
    old = exp_mem[{d, a}];
    lat_q.delete();
    lat_a.delete();
    cur_dev = d;
    @(posedge clk_i);
    req_i   <= 1'b1;
    dev_i   <= d;
    addr_i  <= a;
    wdata_i <= w;
    @(posedge clk_i);
    req_i <= 1'b0;
    if (intr) begin
      repeat (3) @(posedge clk_i);
      #1 check(ready_o, 0);
      @(posedge clk_i);
      req_i   <= 1'b1;
      addr_i  <= ~a;
      wdata_i <= ~w;
      @(posedge clk_i);
      req_i <= 1'b0;
    end
    for (i = 0; i < 5000 && done_o !== 1'b1; i++) begin
      @(posedge clk_i);
      #1;
    end
    if (!wp) exp_mem[{d, a}] = w;
    check(done_o, 1);
    check(rdata_o, exp_mem[{d, a}]);
    check(ok_o, exp_mem[{d, a}] == w);
    check(i_latched_mem_model.mem[{d, a}], exp_mem[{d, a}]);
    check(i_latched_mem_model.mem[{d, ~a}], exp_mem[{d, ~a}]);
    check(lat_q.size(), 2);
    check(lat_q[0], 8'hff);
    check(lat_q[1], w);
    check(lat_a[0], a);
    check(lat_a[1], a);
    if (wp) check(old, exp_mem[{d, a}]);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    rstn_i  = 1'b0;
    req_i   = 1'b0;
    wp      = 1'b0;
    addr_i  = 11'h000;
    dev_i   = 1'b0;
    wdata_i = 8'h00;
    cur_dev = 1'b0;
    for (int i = 0; i < 4096; i++) exp_mem[i] = 8'hff;
    r = $urandom(32'h0de0);
    repeat (10) @(posedge clk_i);
    rstn_i <= 1'b1;
    #1 check(mem_o.we_n, 1);
    check(ready_o, 1);
    update(1'b0, 11'h000, 8'h00, 1'b0);
    update(1'b1, 11'h7ff, 8'hff, 1'b0);
    update(1'b0, 11'h000, 8'h5a, 1'b1);
    for (int k = 0; k < 12; k++) begin
      r = $urandom;
      update(r[0], r[11:1], r[19:12], 1'b0);
    end
    // write refused by the memory, verify must fail
    wp <= 1'b1;
    update(1'b1, 11'h7fe, 8'h3c, 1'b0);
    wp <= 1'b0;
    // reset in the middle of a write pulse
    @(posedge clk_i);
    req_i  <= 1'b1;
    addr_i <= 11'h123;
    @(posedge clk_i);
    req_i <= 1'b0;
    wait (mem_o.we_n === 1'b0);
    repeat (3) @(posedge clk_i);
    rstn_i <= 1'b0;
    #1 check(mem_o.we_n, 1);
    check(ready_o, 1);
    repeat (10) @(posedge clk_i);
    rstn_i <= 1'b1;
    update(dev_i, 11'h123, 8'ha5, 1'b0);
    summarize();
  end

  // hang guard
  initial begin
    #400000;
    miscompares++;
    summarize();
  end
endmodule

// ### bench/latched_mem_model.sv
/*
  behavioural model of two byte-wide latched nonvolatile memories.
  assumes the controller pins and a free running clock for pulse timing.
*/
`timescale 1ns/1ps
module latched_mem_model #(
  parameter int TWP_MIN = 20
) (
  input  wire logic                       clk_i,
  input  wire logic                       wp_i,
  input  wire eeprom_gate_pkg::mem_pins_t mem_i,
  output logic [7:0]                      dq_o
);
  // ****************************************
  // storage and pin latches
  // ****************************************
  logic [7:0]  mem [0:4095];
  logic [11:0] lat_idx;
  logic [7:0]  lat_data;
  logic        lat_ok = 1'b0;
  logic        we_prev = 1'b1;
  logic [7:0]  last_q = 8'h00;
  int          low_cnt = 0;
  logic        drive;

  // erased array at power up
  initial begin
    for (int i = 0; i < 4096; i++) mem[i] = 8'hff;
  end

  // sample settled pins away from the driving edge
  always @(negedge clk_i) begin
    if (mem_i.we_n == 1'b0 && we_prev == 1'b1) begin
      lat_idx  <= {mem_i.cs_n[0], mem_i.addr};
      lat_data <= mem_i.dout_oe ? mem_i.dout : ~mem_i.dout; // undriven bus is garbage
      lat_ok   <= !mem_i.ce_n && mem_i.oe_n && (mem_i.cs_n != 2'b11);
    end
    // all-ones erases, others only clear bits
    if (mem_i.we_n && !we_prev && lat_ok && !wp_i && low_cnt >= TWP_MIN) begin
      mem[lat_idx] <= (lat_data == 8'hff) ? 8'hff : (mem[lat_idx] & lat_data);
    end
    low_cnt <= mem_i.we_n ? 0 : low_cnt + 1;
    we_prev <= mem_i.we_n;
    if (drive) last_q <= dq_o;
  end

  assign drive = !mem_i.ce_n && !mem_i.oe_n && mem_i.we_n && (mem_i.cs_n != 2'b11);
  assign dq_o  = drive ? mem[{mem_i.cs_n[0], mem_i.addr}] : ~last_q; // released bus
endmodule

// ### hdl/eeprom_gate_pkg.sv
/*
  shared constants, state types and pin bundles for the latched
  nonvolatile memory update controller and its write strobe gate.
  assumes one 50 MHz clock and byte-wide memories of 2k locations.
*/
package eeprom_gate_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int TWP_MS        = 10;    // write pulse time
  localparam int TWR_NS        = 1000;  // write recovery between reads
  localparam int TACC_NS       = 350;   // read access allowance
  localparam int ADDR_SETUP_NS = 40;    // address settle before write
  localparam int SYNC_STAGES   = 3;

  // least time in ns to whole clock cycles, never below one
  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  // ****************************************
  // widths and values
  // ****************************************
  localparam int ADDR_W = 11;
  localparam int DATA_W = 8;
  localparam int DEV_W  = 1;
  localparam int N_DEV  = 1 << DEV_W;
  localparam int CNT_W  = 24;
  localparam logic [DATA_W-1:0] ERASE_BYTE = 8'hff;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [7:0] {
    ST_IDLE   = 8'h01,
    ST_SETUP  = 8'h02,
    ST_STROBE = 8'h04,
    ST_PULSE  = 8'h08,
    ST_TERM   = 8'h10,
    ST_RECOV  = 8'h20,
    ST_VERIFY = 8'h40,
    ST_DONE   = 8'h80
  } ctrl_state_t;

  typedef struct packed {
    ctrl_state_t       state;
    logic [CNT_W-1:0]  cnt;
    logic              erase;
    logic [ADDR_W-1:0] addr;
    logic [DEV_W-1:0]  dev;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] dout;
    logic [DATA_W-1:0] rdata;
    logic              ok;
    logic              done;
    logic              sel;
    logic              rd;
    logic              wr;
    logic [DATA_W-1:0] sync0;
    logic [DATA_W-1:0] sync1;
    logic [DATA_W-1:0] sync2;
  } ctrl_regs_t;

  typedef struct packed {
    logic we_low;
  } gate_regs_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dout;
    logic              dout_oe;
    logic [N_DEV-1:0]  cs_n;
    logic              ce_n;
    logic              oe_n;
    logic              we_n;
  } mem_pins_t;

endpackage

// ### hdl/eeprom_update_ctrl.sv
/*
  byte update controller for a latched nonvolatile memory: erase,
  timed write pulse, terminating read, recovery and verify read.
  assumes the memory pins connect directly and memory data returns
  asynchronously on mem_dq_i.
*/
`timescale 1ns/1ps

// Summary of operation
// - each byte is erased before new data is written
// - erase is a normal write carrying the all-ones byte
// - address and select settle before the write command starts
// - selected write command sets the latch, pulling strobe low
// - strobe stays low for the whole timed write pulse
// - any read of the selected memory clears the latch
// - a verify read follows the ending read after recovery time
// - erase, wait, read, write data, wait, read, verify read
// - one latch for all devices, select is OR of chip selects
// - address held stable apart from data lines
// - chip enable follows select, output enable follows read
// - output enable rises at terminating read end, chip enable holds
// - system reset clears the strobe latch
module eeprom_update_ctrl #(
  parameter int TWP_CYC =
    (eeprom_gate_pkg::TWP_MS * 1000000 + eeprom_gate_pkg::CLK_PERIOD_NS - 1)
    / eeprom_gate_pkg::CLK_PERIOD_NS
) (
  input  wire logic                                clk_i,
  input  wire logic                                rstn_i,
  input  wire logic                                req_i,
  input  wire logic [eeprom_gate_pkg::ADDR_W-1:0]  addr_i,
  input  wire logic [eeprom_gate_pkg::DEV_W-1:0]   dev_i,
  input  wire logic [eeprom_gate_pkg::DATA_W-1:0]  wdata_i,
  output logic                                     ready_o,
  output logic                                     done_o,
  output logic                                     ok_o,
  output logic [eeprom_gate_pkg::DATA_W-1:0]       rdata_o,
  input  wire logic [eeprom_gate_pkg::DATA_W-1:0]  mem_dq_i,
  output eeprom_gate_pkg::mem_pins_t               mem_o
);

  localparam int SETUP_CYC = eeprom_gate_pkg::ns_to_cyc(eeprom_gate_pkg::ADDR_SETUP_NS);
  localparam int TWR_CYC   = eeprom_gate_pkg::ns_to_cyc(eeprom_gate_pkg::TWR_NS);
  localparam int RD_CYC    = eeprom_gate_pkg::ns_to_cyc(eeprom_gate_pkg::TACC_NS)
                             + eeprom_gate_pkg::SYNC_STAGES;

  eeprom_gate_pkg::ctrl_regs_t s_reg;
  eeprom_gate_pkg::ctrl_regs_t s_next;
  logic                        array_select;
  logic                        we_n;

  // ****************************************
  // sequencer
  // ****************************************
  always_comb begin
    s_next       = s_reg;
    s_next.done  = 1'b0;
    s_next.sync0 = mem_dq_i;  // pin data through three stages
    s_next.sync1 = s_reg.sync0;
    s_next.sync2 = s_reg.sync1;
    case (s_reg.state)
      eeprom_gate_pkg::ST_IDLE: begin
        if (req_i) begin
          s_next.addr  = addr_i;
          s_next.dev   = dev_i;
          s_next.wdata = wdata_i;
          s_next.erase = 1'b1;
          s_next.dout  = eeprom_gate_pkg::ERASE_BYTE;
          s_next.sel   = 1'b1;
          s_next.cnt   = CNT_W_CAST(SETUP_CYC - 1);
          s_next.state = eeprom_gate_pkg::ST_SETUP;
        end
      end
      eeprom_gate_pkg::ST_SETUP: begin
        if (s_reg.cnt == '0) begin
          s_next.wr    = 1'b1;
          s_next.state = eeprom_gate_pkg::ST_STROBE;
        end else begin
          s_next.cnt = s_reg.cnt - 1'b1;
        end
      end
      eeprom_gate_pkg::ST_STROBE: begin
        s_next.wr    = 1'b0;
        s_next.cnt   = CNT_W_CAST(TWP_CYC - 1);
        s_next.state = eeprom_gate_pkg::ST_PULSE;
      end
      eeprom_gate_pkg::ST_PULSE: begin
        if (s_reg.cnt == '0) begin
          s_next.rd    = 1'b1;
          s_next.cnt   = CNT_W_CAST(RD_CYC - 1);
          s_next.state = eeprom_gate_pkg::ST_TERM;
        end else begin
          s_next.cnt = s_reg.cnt - 1'b1;
        end
      end
      eeprom_gate_pkg::ST_TERM: begin
        if (s_reg.cnt == '0) begin
          s_next.rd    = 1'b0;
          s_next.cnt   = CNT_W_CAST(TWR_CYC - 1);
          s_next.state = eeprom_gate_pkg::ST_RECOV;
        end else begin
          s_next.cnt = s_reg.cnt - 1'b1;
        end
      end
      eeprom_gate_pkg::ST_RECOV: begin
        if (s_reg.cnt != '0) begin
          s_next.cnt = s_reg.cnt - 1'b1;
        end else if (s_reg.erase) begin
          s_next.erase = 1'b0;
          s_next.dout  = s_reg.wdata;
          s_next.cnt   = CNT_W_CAST(SETUP_CYC - 1);
          s_next.state = eeprom_gate_pkg::ST_SETUP;
        end else begin
          s_next.rd    = 1'b1;
          s_next.cnt   = CNT_W_CAST(RD_CYC - 1);
          s_next.state = eeprom_gate_pkg::ST_VERIFY;
        end
      end
      eeprom_gate_pkg::ST_VERIFY: begin
        if (s_reg.cnt != '0) begin
          s_next.cnt = s_reg.cnt - 1'b1;
        end else if (s_reg.sync1 == s_reg.sync2) begin
          s_next.rdata = s_reg.sync2;
          s_next.ok    = (s_reg.sync2 == s_reg.wdata);
          s_next.rd    = 1'b0;
          s_next.sel   = 1'b0;
          s_next.done  = 1'b1;
          s_next.state = eeprom_gate_pkg::ST_DONE;
        end
      end
      eeprom_gate_pkg::ST_DONE: begin
        s_next.state = eeprom_gate_pkg::ST_IDLE;
      end
      default: begin
        s_next.state = eeprom_gate_pkg::ST_IDLE;
      end
    endcase
  end

  // size cast for counter loads
  function automatic logic [eeprom_gate_pkg::CNT_W-1:0] CNT_W_CAST(input int v);
    return v[eeprom_gate_pkg::CNT_W-1:0];
  endfunction

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_reg       <= '0;
      s_reg.state <= eeprom_gate_pkg::ST_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************************************
  // memory pins
  // ****************************************
  // select is OR of chip selects
  assign array_select = |(~mem_o.cs_n);

  strobe_gate u_gate (
    .clk_i          (clk_i),
    .rstn_i         (rstn_i),
    .array_select_i (array_select),
    .mem_wr_i       (s_reg.wr),
    .mem_rd_i       (s_reg.rd),
    .we_n_o         (we_n)
  );

  always_comb begin
    mem_o.addr    = s_reg.addr;
    mem_o.dout    = s_reg.dout;
    mem_o.dout_oe = (s_reg.state == eeprom_gate_pkg::ST_SETUP)
                    || (s_reg.state == eeprom_gate_pkg::ST_STROBE)
                    || (s_reg.state == eeprom_gate_pkg::ST_PULSE);
    mem_o.cs_n    = s_reg.sel ? ~(eeprom_gate_pkg::N_DEV'(1) << s_reg.dev)
                              : '1;
    mem_o.ce_n    = ~s_reg.sel;
    mem_o.oe_n    = ~(s_reg.sel && s_reg.rd);
    mem_o.we_n    = we_n;
  end

  // user side
  assign ready_o = (s_reg.state == eeprom_gate_pkg::ST_IDLE);
  assign done_o  = s_reg.done;
  assign ok_o    = s_reg.ok;
  assign rdata_o = s_reg.rdata;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  property p_setup_first;
    $rose(s_reg.wr) |-> $past(s_reg.state == eeprom_gate_pkg::ST_SETUP) && $past(s_reg.sel);
  endproperty
  a_setup_first: assert property (p_setup_first) else $error("write before setup");

  property p_erase_first;
    (ready_o && req_i) |=> (s_reg.erase && s_reg.dout == eeprom_gate_pkg::ERASE_BYTE);
  endproperty
  a_erase_first: assert property (p_erase_first) else $error("no erase first");

  property p_erase_ones;
    (s_reg.wr && s_reg.erase) |-> (mem_o.dout == 8'hff) && mem_o.dout_oe;
  endproperty
  a_erase_ones: assert property (p_erase_ones) else $error("erase data not ones");

  sequence s_pulse_start;
    $rose(s_reg.state == eeprom_gate_pkg::ST_PULSE);
  endsequence
  property p_pulse_low;
    s_pulse_start |=> !mem_o.we_n [*8];
  endproperty
  a_pulse_low: assert property (p_pulse_low) else $error("strobe rose in pulse");

  property p_verify_after_recov;
    $rose(s_reg.state == eeprom_gate_pkg::ST_VERIFY)
      |-> $past(s_reg.state == eeprom_gate_pkg::ST_RECOV) && !s_reg.erase;
  endproperty
  a_verify_after_recov: assert property (p_verify_after_recov) else $error("bad verify");

  sequence s_erase_end;
    $fell(s_reg.erase);
  endsequence
  property p_data_phase;
    s_erase_end |-> $past(s_reg.state == eeprom_gate_pkg::ST_RECOV)
                    && (s_reg.dout == s_reg.wdata) && mem_o.we_n;
  endproperty
  a_data_phase: assert property (p_data_phase) else $error("bad data phase");

  property p_read_enables;
    $rose(s_reg.rd) |-> !mem_o.oe_n && !mem_o.ce_n;
  endproperty
  a_read_enables: assert property (p_read_enables) else $error("read enables off");

  property p_read_end;
    ($fell(s_reg.rd) && s_reg.state == eeprom_gate_pkg::ST_RECOV)
      |-> mem_o.oe_n && !mem_o.ce_n;
  endproperty
  a_read_end: assert property (p_read_end) else $error("read end enables wrong");

endmodule

// ### hdl/strobe_gate.sv
/*
  set/reset latch holding the memory write strobe low.
  assumes read and write commands come from logic on the same clock.
*/
`timescale 1ns/1ps
module strobe_gate (
  input  wire logic clk_i,
  input  wire logic rstn_i,
  input  wire logic array_select_i,
  input  wire logic mem_wr_i,
  input  wire logic mem_rd_i,
  output logic      we_n_o
);

  eeprom_gate_pkg::gate_regs_t s_reg;
  eeprom_gate_pkg::gate_regs_t s_next;

  // latch set and reset
  always_comb begin
    s_next = s_reg;
    if (array_select_i && mem_rd_i) begin
      s_next.we_low = 1'b0;
    end else if (array_select_i && mem_wr_i) begin
      s_next.we_low = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign we_n_o = ~s_reg.we_low;

  // ****************************************
  // checks
  // ****************************************
  property p_set_on_write;
    @(posedge clk_i) disable iff (!rstn_i)
      (array_select_i && mem_wr_i && !mem_rd_i) |=> !we_n_o;
  endproperty
  a_set_on_write: assert property (p_set_on_write) else $error("strobe not set");

  property p_read_ends;
    @(posedge clk_i) disable iff (!rstn_i)
      (array_select_i && mem_rd_i) |=> we_n_o;
  endproperty
  a_read_ends: assert property (p_read_ends) else $error("read left strobe low");

  property p_unselected;
    @(posedge clk_i) disable iff (!rstn_i)
      (!array_select_i && we_n_o) |=> we_n_o;
  endproperty
  a_unselected: assert property (p_unselected) else $error("strobe set unselected");

endmodule
